// ---- src/adc_seq_map.svh ----
`ifndef ADC_SEQ_MAP_SVH
`define ADC_SEQ_MAP_SVH

// Word addresses and address region codes on the converter bus interface
`define ADR_CTL_FIRST  6'h00
`define ADR_CTL_SECOND 6'h01
`define ADR_STATUS     6'h02
`define RGN_URJ        3'h2
`define RGN_SLJ        3'h3
`define RGN_ULJ        3'h4

// Control and status field positions
`define CF_RES10_BIT   7
`define CF_STS_LSB     4
`define CS_EIGHT_CONV_SELECT_BIT    6
`define CS_SCAN_BIT    5
`define CS_MULTI_CHANNEL_SELECT_BIT    4
`define ST_SEQ_BIT     15
`define ST_BUSY_BIT    8

// Phase lengths in converter clocks, bit counts and first trial codes
`define INIT_CYC       5'h02
`define XFER_CYC       5'h02
`define FINAL_MIN_CYC  5'h02
`define RES8_CYC       5'h0a
`define RES10_CYC      5'h0c
`define BITS8          4'h8
`define BITS10         4'ha
`define SAR_MSB10      10'h200
`define SAR_MSB8       10'h080
`endif

// ---- src/adc_seq_pkg.sv ----
package adc_seq_pkg;
  typedef enum logic [2:0] {PH_IDLE, PH_INIT, PH_XFER, PH_FINAL, PH_RES} phase_type;
  typedef enum logic [1:0] {V_URJ, V_SLJ, V_ULJ, V_NONE} view_type;
  typedef struct packed {
    logic       res10;
    logic [1:0] sts;
  } ctl_first_type;
  typedef struct packed {
    logic       eight_conv_select;
    logic       scan;
    logic       multi_channel_select;
    logic [3:0] chan;
  } ctl_second_type;
endpackage

// ---- src/adc_sequencer.sv ----
`timescale 1ns/1ps
`include "adc_seq_map.svh"
module adc_sequencer
  import adc_seq_pkg::*;
#(
  parameter int NUM_SLOTS = 8
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Converter bus interface
  input  wire logic        bus_sel,
  input  wire logic        bus_wr,
  input  wire logic [5:0]  bus_addr,
  input  wire logic [15:0] bus_wdata,
  output logic      [15:0] bus_rdata,
  output logic             bus_ack,
  // Analog front end
  output logic      [3:0]  chan_sel,
  output logic             samp_init,
  output logic             xfer,
  output logic             samp_final,
  output logic             resolve,
  output logic      [9:0]  dac_code,
  input  wire logic        cmp_hi
);

  // Slot decode and flag vector are sized for eight slots
  if (NUM_SLOTS != 8) begin : g_bad_slots
    $error("NUM_SLOTS must be 8");
  end

  ctl_first_type  cf_q;
  ctl_second_type cs_q;
  phase_type      ph_q, ph_d;
  logic [4:0]     cnt_q, cnt_d;
  logic [2:0]     idx_q, idx_d;
  logic [9:0]     sar_q, sar_d;
  logic [9:0]     slot_q [8];
  logic [7:0]     ccf_q;
  logic           scf_q;
  logic [15:0]    rdata_q;
  logic           ack_q;

  function automatic logic [4:0] ph_last(phase_type p, logic [1:0] s, logic r10);
    case (p)
      PH_INIT:  ph_last = `INIT_CYC - 5'h01;
      PH_XFER:  ph_last = `XFER_CYC - 5'h01;
      PH_FINAL: ph_last = (`FINAL_MIN_CYC << s) - 5'h01;
      PH_RES:   ph_last = (r10 ? `RES10_CYC : `RES8_CYC) - 5'h01;
      default:  ph_last = 5'h00;
    endcase
  endfunction

  function automatic logic [15:0] fmt(view_type v, logic [9:0] l, logic r10);
    logic [9:0] u;
    u = r10 ? l : {l[9:2], 2'b00};
    case (v)
      V_URJ:   fmt = r10 ? {6'h00, l} : {8'h00, l[9:2]};
      V_SLJ:   fmt = {~u[9], u[8:0], 6'h00};
      V_ULJ:   fmt = {u, 6'h00};
      default: fmt = 16'h0000;
    endcase
  endfunction

  // Bus decode
  wire        wr_hit   = bus_sel & bus_wr;
  wire        rd_hit   = bus_sel & ~bus_wr;
  wire        start    = wr_hit & (bus_addr == `ADR_CTL_SECOND);
  wire        wr_first = wr_hit & (bus_addr == `ADR_CTL_FIRST);
  wire [2:0]  rgn      = bus_addr[5:3];
  // View picked by address region only
  // view from address
  wire view_type view  = (rgn == `RGN_URJ) ? V_URJ :
                         (rgn == `RGN_SLJ) ? V_SLJ :
                         (rgn == `RGN_ULJ) ? V_ULJ : V_NONE;
  wire [2:0]  mode     = {cs_q.scan, cs_q.multi_channel_select, cs_q.eight_conv_select};
  wire [2:0]  last_idx = mode[0] ? 3'h7 : 3'h3;
  wire        busy     = (ph_q != PH_IDLE);
  wire [4:0]  last     = ph_last(ph_q, cf_q.sts, cf_q.res10);
  wire        ph_end   = busy & (cnt_q == last);
  wire        store    = (ph_q == PH_RES) & ph_end;
  // 8-bit results sit in the low byte of the array code
  // bit count from resolution
  wire [3:0]  nbits    = cf_q.res10 ? `BITS10 : `BITS8;
  wire [3:0]  sar_bit  = nbits - cnt_q[3:0];
  wire [9:0]  sar_left = cf_q.res10 ? sar_q : {sar_q[7:0], 2'b00};
  wire [15:0] status   = {scf_q, 6'h00, busy, ccf_q};
  wire [15:0] slot_rd  = fmt(view, slot_q[bus_addr[2:0]], cf_q.res10);
  wire [15:0] rd_word  = (bus_addr == `ADR_CTL_FIRST)  ? {8'h00, cf_q.res10, 1'b0,
                                                          cf_q.sts, 4'h0} :
                         (bus_addr == `ADR_CTL_SECOND) ? {9'h000, cs_q} :
                         (bus_addr == `ADR_STATUS)     ? status : slot_rd;

  assign chan_sel   = ~mode[1] ? cs_q.chan :
                      mode[0]  ? {cs_q.chan[3], idx_q} :
                                 {cs_q.chan[3:2], idx_q[1:0]};
  assign samp_init  = (ph_q == PH_INIT);
  assign xfer       = (ph_q == PH_XFER);
  assign samp_final = (ph_q == PH_FINAL);
  assign resolve    = (ph_q == PH_RES);
  assign dac_code   = sar_q;
  assign bus_rdata  = rdata_q;
  assign bus_ack    = ack_q;

  always_comb begin
    ph_d  = ph_q;
    cnt_d = ph_end ? 5'h00 : cnt_q + 5'h01;
    idx_d = idx_q;
    sar_d = sar_q;
    case (ph_q)
      PH_IDLE:  cnt_d = 5'h00;
      PH_INIT:  if (ph_end) ph_d = PH_XFER;
      PH_XFER:  if (ph_end) ph_d = PH_FINAL;
      PH_FINAL: if (ph_end) ph_d = PH_RES;
      PH_RES: begin
        if (cnt_q == 5'h00) begin
          sar_d = cf_q.res10 ? `SAR_MSB10 : `SAR_MSB8;
        end else if (!store) begin
          if (!cmp_hi) sar_d[sar_bit] = 1'b0;
          if (sar_bit != 4'h0) sar_d[sar_bit - 4'h1] = 1'b1;
        end else if (idx_q == last_idx) begin
          idx_d = 3'h0;
          ph_d  = cs_q.scan ? PH_INIT : PH_IDLE;
        end else begin
          idx_d = idx_q + 3'h1;
          ph_d  = PH_INIT;
        end
      end
      default: ph_d = PH_IDLE;
    endcase
    if (start) begin
      ph_d  = PH_INIT;
      cnt_d = 5'h00;
      idx_d = 3'h0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ph_q  <= PH_IDLE;
      cnt_q <= 5'h00;
      idx_q <= 3'h0;
      sar_q <= 10'h000;
    end else begin
      ph_q  <= ph_d;
      cnt_q <= cnt_d;
      idx_q <= idx_d;
      sar_q <= sar_d;
    end
  end

  // Control registers; writing the second one restarts the sequence
  always_ff @(posedge clk) begin
    if (rst) begin
      cf_q <= '0;
      cs_q <= '0;
    end else begin
      if (wr_first) begin
        cf_q <= {bus_wdata[`CF_RES10_BIT], bus_wdata[`CF_STS_LSB +: 2]};
      end
      if (start) begin
        cs_q <= {bus_wdata[`CS_EIGHT_CONV_SELECT_BIT], bus_wdata[`CS_SCAN_BIT],
                 bus_wdata[`CS_MULTI_CHANNEL_SELECT_BIT], bus_wdata[3:0]};
      end
    end
  end

  // Restart clears flags; a store in the same cycle still sets
  always_ff @(posedge clk) begin
    if (rst) begin
      ccf_q <= 8'h00;
      scf_q <= 1'b0;
    end else begin
      if (start) begin
        ccf_q <= 8'h00;
        scf_q <= 1'b0;
      end
      if (store) begin
        ccf_q[idx_q] <= 1'b1;
        if (idx_q == last_idx) scf_q <= 1'b1;
      end
    end
  end

  // Result slots; bus writes never reach them
  // copy to slot
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_slot
      always_ff @(posedge clk) begin
        if (rst) slot_q[g] <= 10'h000;
        else if (store && idx_q == g) slot_q[g] <= sar_left;
      end
    end
  endgenerate

  // Registered read data, one cycle after the request
  // slots only via bus
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_q <= 16'h0000;
      ack_q   <= 1'b0;
    end else begin
      ack_q <= bus_sel;
      if (rd_hit) rdata_q <= rd_word;
    end
  end

  property p_init_len;
    @(posedge clk) disable iff (rst || start)
      $rose(samp_init) |-> samp_init ##1 samp_init ##1 xfer;
  endproperty
  a_init_len: assert property (p_init_len) else $error("initial sample not 2 cycles");

  property p_xfer_len;
    @(posedge clk) disable iff (rst || start)
      $rose(xfer) |-> xfer[*2] ##1 samp_final;
  endproperty
  a_xfer_len: assert property (p_xfer_len) else $error("transfer not 2 cycles");

  // Own run counter, so the check does not lean on the phase counter
  logic [4:0]     fin_run_q;
  always_ff @(posedge clk) begin
    if (rst || !samp_final) fin_run_q <= 5'h00;
    else fin_run_q <= fin_run_q + 5'h01;
  end

  property p_final_len;
    @(posedge clk) disable iff (rst)
      $rose(resolve) |-> fin_run_q == (`FINAL_MIN_CYC << cf_q.sts);
  endproperty
  a_final_len: assert property (p_final_len) else $error("final sample length wrong");

  property p_res8_len;
    @(posedge clk) disable iff (rst || start)
      ($rose(resolve) && !cf_q.res10) |-> !store[*8] ##1 !store ##1 store;
  endproperty
  a_res8_len: assert property (p_res8_len) else $error("8-bit resolution not 10");

  property p_res10_len;
    @(posedge clk) disable iff (rst || start)
      ($rose(resolve) && cf_q.res10) |-> ##11 store;
  endproperty
  a_res10_len: assert property (p_res10_len) else $error("10-bit resolution not 12");

  property p_sar_init;
    @(posedge clk) disable iff (rst || start)
      $rose(resolve) |=> dac_code == (cf_q.res10 ? 10'h200 : 10'h080);
  endproperty
  a_sar_init: assert property (p_sar_init) else $error("approximation start wrong");

  property p_store;
    @(posedge clk) disable iff (rst)
      store |=> slot_q[$past(idx_q)] == $past(sar_left) && ccf_q[$past(idx_q)];
  endproperty
  a_store: assert property (p_store) else $error("slot or flag not updated");

  property p_urj_zero;
    @(posedge clk) disable iff (rst)
      (rd_hit && view == V_URJ) |=> bus_rdata[15:10] == 6'h00;
  endproperty
  a_urj_zero: assert property (p_urj_zero) else $error("right view upper bits set");

  property p_ljust_zero;
    @(posedge clk) disable iff (rst)
      (rd_hit && (view == V_SLJ || view == V_ULJ)) |=> bus_rdata[5:0] == 6'h00;
  endproperty
  a_ljust_zero: assert property (p_ljust_zero) else $error("left view low bits set");

  property p_chan_multi4;
    @(posedge clk) disable iff (rst)
      (busy && mode[1:0] == 2'b10) |-> chan_sel == {cs_q.chan[3:2], idx_q[1:0]};
  endproperty
  a_chan_multi4: assert property (p_chan_multi4) else $error("channel map wrong");

  property p_phase_order;
    @(posedge clk) disable iff (rst)
      $rose(resolve) |-> $past(samp_final);
  endproperty
  a_phase_order: assert property (p_phase_order) else $error("resolve not after final");

  // Stored codes are left-justified, so bit 9 is the top result bit
  wire        slot_top = slot_q[bus_addr[2:0]][9];

  property p_slj_sign;
    @(posedge clk) disable iff (rst)
      (rd_hit && view == V_SLJ) |=> bus_rdata[15] == !$past(slot_top);
  endproperty
  a_slj_sign: assert property (p_slj_sign) else $error("signed view top bit wrong");

endmodule

// ---- verification/cmp_model.sv ----
`timescale 1ns/1ps
module cmp_model (
  // Converter front end
  input  wire logic       clk,
  input  wire logic [3:0] chan_sel,
  input  wire logic       resolve,
  input  wire logic [9:0] dac_code,
  output logic            cmp_hi,
  // Bench control
  input  wire logic       res10,
  input  wire logic [9:0] bias
);
  logic       idle_q = 1'b0;
  logic [9:0] level;
  // Each channel has its own level, XORed with the bench bias
  assign level = {chan_sel, chan_sel, 2'b10} ^ bias;
  // Outside resolution the output wanders, never holds
  always_ff @(posedge clk) idle_q <= ~idle_q;
  assign cmp_hi = !resolve ? idle_q :
                  res10 ? (level >= dac_code) : (level[9:2] >= dac_code[7:0]);
endmodule

// ---- verification/adc_sequencer_test.sv ----
`timescale 1ns/1ps
`include "adc_seq_map.svh"
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_mismatch++; \
  $display("mismatch %0t got %h exp %h", $time, a, b); end end
module adc_sequencer_test;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        bus_sel = 1'b0;
  logic        bus_wr = 1'b0;
  logic [5:0]  bus_addr = 6'h00;
  logic [15:0] bus_wdata = 16'h0000;
  logic [15:0] bus_rdata;
  logic        bus_ack;
  logic [3:0]  chan_sel;
  logic        samp_init, xfer, samp_final, resolve, cmp_hi;
  logic [9:0]  dac_code;
  logic        res10 = 1'b0;
  logic [9:0]  bias = 10'h000;
  logic [6:0]  mode_q = 7'h00;
  logic [15:0] rd;
  logic [2:0]  rgn[3] = '{`RGN_URJ, `RGN_SLJ, `RGN_ULJ};
  int          n_mismatch = 0;
  int          tests_run = 0;
  int          conv_idx = 0;
  int          cnt[4];
  int          len[4];
  wire [3:0]   strobes = {resolve, samp_final, xfer, samp_init};

  always #20 clk = ~clk;

  adc_sequencer dut (.clk, .rst, .bus_sel, .bus_wr, .bus_addr, .bus_wdata, .bus_rdata,
    .bus_ack, .chan_sel, .samp_init, .xfer, .samp_final, .resolve, .dac_code, .cmp_hi);
  cmp_model far_end (.clk, .chan_sel, .resolve, .dac_code, .cmp_hi, .res10, .bias);

  function automatic logic [15:0] view(int v, logic [3:0] ch);
    logic [9:0]  a;
    logic [15:0] l;
    a = {ch, ch, 2'b10} ^ bias;
    l = res10 ? {a, 6'h00} : {a[9:2], 8'h00};
    if (v == 0) return res10 ? {6'h00, a} : {8'h00, a[9:2]};
    return (v == 1) ? l ^ 16'h8000 : l;
  endfunction

  function automatic logic [3:0] exp_ch(int i);
    if (!mode_q[4]) return mode_q[3:0];
    return mode_q[6] ? {mode_q[3], 3'(i)} : {mode_q[3:2], 2'(i)};
  endfunction

  task automatic wrap_up;
    if (n_mismatch == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic bus(input logic w, input logic [5:0] a, input logic [15:0] d);
    @(posedge clk);
    #1 bus_sel = 1'b1;
    bus_wr = w;
    bus_addr = a;
    bus_wdata = d;
    @(posedge clk);
    #1 bus_sel = 1'b0;
    rd = bus_rdata;
    `CHK(bus_ack, 1'b1)
  endtask

  task automatic wait_seq;
    for (int k = 0; k < 300; k++) begin
      bus(1'b0, `ADR_STATUS, 16'h0000);
      if (rd[`ST_SEQ_BIT] === 1'b1) return;
    end
    n_mismatch++;
    wrap_up();
  endtask

  // Phase run lengths, channel order, first trial value
  always @(negedge clk) begin
    for (int p = 0; p < 4; p++) begin
      if (strobes[p] === 1'b1) cnt[p]++;
      else if (cnt[p] != 0) begin
        len[p] = cnt[p];
        cnt[p] = 0;
      end
    end
    // Every initial cycle: a restart can stretch that phase
    if (samp_init === 1'b1)
      `CHK(chan_sel, exp_ch(conv_idx))
    if (xfer === 1'b1 && cnt[1] == 1) conv_idx++;
    if (resolve === 1'b1 && cnt[3] == 2)
      `CHK(dac_code, res10 ? `SAR_MSB10 : `SAR_MSB8)
  end

  initial begin
    repeat (4) @(posedge clk);
    #1 rst = 1'b0;
    bus(1'b0, `ADR_STATUS, 16'h0000);
    `CHK(rd, 16'h0000)
    bus(1'b0, {`RGN_URJ, 3'h0}, 16'h0000);
    `CHK(rd, 16'h0000)
    bus(1'b0, 6'h3f, 16'h0000);
    `CHK(rd, 16'h0000)
    // Every mode once; each sample time twice, each resolution four times
    for (int m = 0; m < 8; m++) begin
      bus(1'b1, `ADR_CTL_SECOND, {9'h000, m[0], m[2], m[1], 4'(2 * m + 1)});
      mode_q = {m[0], m[2], m[1], 4'(2 * m + 1)};
      conv_idx = 0;
      bus(1'b1, `ADR_CTL_FIRST, {8'h00, m[0] ^ m[2], 1'b0, 2'(m >> 1), 4'h0});
      res10 = m[0] ^ m[2];
      wait_seq();
      `CHK(rd, {1'b1, 6'h00, m[2], m[0] ? 8'hff : 8'h0f})
      `CHK(len[0], 2)
      `CHK(len[1], 2)
      `CHK(len[2], 2 << (m >> 1))
      `CHK(len[3], res10 ? 12 : 10)
      for (int i = 0; i < (m[0] ? 8 : 4); i++)
        for (int v = 0; v < 3; v++) begin
          bus(1'b0, {rgn[v], 3'(i)}, 16'h0000);
          `CHK(rd, view(v, exp_ch(i)))
        end
    end
    // Scan keeps running; new levels must replace old results
    bias = 10'h3fc;
    for (int k = 0; k < 400; k++) begin
      bus(1'b0, {`RGN_URJ, 3'h7}, 16'h0000);
      if (rd === view(0, exp_ch(7))) break;
    end
    `CHK(rd, view(0, exp_ch(7)))
    bus(1'b1, {`RGN_URJ, 3'h7}, 16'hffff);
    bus(1'b0, {`RGN_URJ, 3'h7}, 16'h0000);
    `CHK(rd, view(0, exp_ch(7)))
    bus(1'b1, `ADR_STATUS, 16'h0000);
    bus(1'b0, `ADR_STATUS, 16'h0000);
    `CHK(rd, 16'h81ff)
    wrap_up();
  end
endmodule
